// >>> operand_address_decode.v
// operand notation decode, effective/target address forming and fetch pacing
// assumes synchronous inputs on clk and config bits stable from a reset fetch
// all configuration is taken once, on the first clock after reset
//
// How it works
// - one state equals two system clocks
// - internal code fetch brings sixteen bits
// - external code buffered in prefetch queue
// - page one state, non-page two plus waits
// - short direct low half RAM, high SFR
// - short direct width follows other operand
// - long direct confined to lowest 64K
// - byte immediate 8 bits, word 16
// - double word immediates zero/one extended
// - short immediate field gives 1,2,4
// - legacy bit low half maps RAM 20h-2Fh
// - legacy bit high half maps SFR x0/x8
// - extended bit reaches low RAM or SFR
// - relative: signed byte plus next address
// - block jump replaces low eleven bits
// - region jump replaces low sixteen bits
// - full jump loads all 24 bits
// - reset config bit picks binary/source mode
// - config bit picks page/non-page mode
// - two-bit code sets three..zero waits
`timescale 1ns/1ns
`include "operand_address_decode_defines.vh"

module operand_address_decode
#(
  parameter QUEUE_DEPTH = 4,                 // prefetch queue bytes
  parameter QUEUE_AW    = 2                  // queue index width
)
(
  input  wire        clk,
  input  wire        resetn,
  // configuration bits sampled at reset release
  input  wire        cfg_source_mode,
  input  wire        cfg_nonpage,
  input  wire        wait_count_hi_n,
  input  wire        wait_count_lo_n,
  // fetch side
  input  wire        code_external,
  input  wire [15:0] int_code_word,
  input  wire        int_code_valid,
  input  wire [7:0]  ext_code_byte,
  input  wire        ext_code_valid,
  output wire        ext_fetch_req,
  // execution side consumes one byte per take
  input  wire        exec_take,
  output wire        exec_byte_valid,
  output reg  [7:0]  exec_byte,
  // operand decode request
  input  wire        op_valid,
  input  wire [3:0]  op_kind,
  input  wire [1:0]  other_width,
  input  wire [23:0] op_field,
  input  wire [23:0] next_pc,
  output reg         res_valid,
  output reg  [23:0] res_addr,
  output reg  [31:0] res_data,
  output reg  [1:0]  res_width,
  output reg         res_is_sfr,
  output reg  [2:0]  res_bit,
  output reg         res_error,
  // mode and pacing status
  output reg         source_mode,
  output reg         page_mode,
  output reg  [2:0]  wait_states,
  output reg         state_tick
);

  // ****************************************************
  // configuration capture
  // ****************************************************
  reg        cfg_done_reg;                   // config already caught

  // config is caught on the first clocked edge out of reset
  // caught once; later changes on the config pins are ignored
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      // page mode with three waits until the config is known
      cfg_done_reg <= 1'b0;
      source_mode  <= 1'b0;
      page_mode    <= 1'b1;
      wait_states  <= 3'd3;
    end
    else if (!cfg_done_reg)
    begin
      cfg_done_reg <= 1'b1;
      // source mode is only reported to the opcode decoder
      source_mode  <= cfg_source_mode;
      page_mode    <= ~cfg_nonpage;
      // inverted pair: 00 three waits .. 11 none
      wait_states  <= 3'd3 - {1'b0, wait_count_hi_n, wait_count_lo_n};
    end
  end

  // ****************************************************
  // state timebase
  // ****************************************************
  reg  [1:0] phase_reg;                      // clocks inside a state

  // state_tick pulses once every two clocks
  // tick is registered, so it rises on the same edge that wraps the phase
  // phase restarts on reset so ticks align to reset release
  // external pacing counts these ticks, never raw clocks
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      phase_reg  <= 2'd0;
      state_tick <= 1'b0;
    end
    else if (phase_reg == `CLKS_PER_STATE - 2'd1)
    begin
      phase_reg  <= 2'd0;
      state_tick <= 1'b1;
    end
    else
    begin
      phase_reg  <= phase_reg + 2'd1;
      state_tick <= 1'b0;
    end
  end

  // ****************************************************
  // prefetch queue
  // ****************************************************
  reg  [7:0]          q_mem [0:QUEUE_DEPTH-1];  // byte storage
  reg  [QUEUE_AW-1:0] q_wr_reg;              // write index
  reg  [QUEUE_AW-1:0] q_rd_reg;              // read index
  reg  [QUEUE_AW:0]   q_cnt_reg;             // bytes held
  reg  [2:0]          pace_reg;              // states left per byte
  wire [2:0]          per_byte;              // states per external byte
  wire                q_full;
  wire                q_empty;
  wire                pace_ok;
  wire [1:0]          push_n;                // bytes pushed now
  wire [QUEUE_AW:0]   push_ext;              // push count at queue width
  wire                pop;
  reg  [7:0]          push_lo;
  reg  [7:0]          push_hi;

  // non-page: base states plus waits for every byte
  assign per_byte = page_mode ? `PAGE_STATES
                  : (`NONPAGE_BASE_STATES + wait_states);
  assign q_full   = (q_cnt_reg == QUEUE_DEPTH);
  assign q_empty  = (q_cnt_reg == {(QUEUE_AW+1){1'b0}});
  assign pace_ok  = (pace_reg == 3'd0);
  // external bytes only enter when paced and room exists
  assign ext_fetch_req = code_external && pace_ok && !q_full
                         && cfg_done_reg;
  // internal word needs two free slots
  assign push_n = (!cfg_done_reg) ? 2'd0
                : code_external ? ((ext_fetch_req && ext_code_valid
                                    && state_tick) ? 2'd1 : 2'd0)
                : ((int_code_valid
                    && (q_cnt_reg <= QUEUE_DEPTH - 2)) ? 2'd2 : 2'd0);
  // widen the push count so index and count adders match
  assign push_ext = {{(QUEUE_AW-1){1'b0}}, push_n};
  assign pop  = exec_take && !q_empty;
  // a byte is offered whenever the queue holds one
  assign exec_byte_valid = !q_empty;

  // choose bytes entering the queue, low byte first
  always @*
  begin
    push_lo = code_external ? ext_code_byte : int_code_word[7:0];
    push_hi = int_code_word[15:8];
  end

  // queue storage and pacing counter
  // q_mem has no reset; exec_byte_valid qualifies the head
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      q_wr_reg  <= {QUEUE_AW{1'b0}};
      q_rd_reg  <= {QUEUE_AW{1'b0}};
      q_cnt_reg <= {(QUEUE_AW+1){1'b0}};
      pace_reg  <= 3'd0;
      exec_byte <= 8'h00;
    end
    else
    begin
      if (push_n != 2'd0)
      begin
        q_mem[q_wr_reg] <= push_lo;
        if (push_n == 2'd2)
          q_mem[q_wr_reg + 1'b1] <= push_hi;
      end
      // a take and a push in one clock both count
      q_wr_reg  <= q_wr_reg + push_ext[QUEUE_AW-1:0];
      q_rd_reg  <= q_rd_reg + {{(QUEUE_AW-1){1'b0}}, pop};
      q_cnt_reg <= q_cnt_reg + {{(QUEUE_AW-1){1'b0}}, push_n}
                   - {{QUEUE_AW{1'b0}}, pop};
      // each external byte blocks further fetch for per_byte states
      if (push_n == 2'd1)
        pace_reg <= per_byte - 3'd1;
      else if (state_tick && !pace_ok)
        pace_reg <= pace_reg - 3'd1;
      // head registered: trails the read index by one clock
      exec_byte <= q_mem[q_rd_reg];
    end
  end

  // ****************************************************
  // operand decode
  // ****************************************************
  // decoded values ahead of the result register
  reg  [23:0] addr_next;
  reg  [31:0] data_next;
  reg  [1:0]  width_next;
  reg         sfr_next;
  reg  [2:0]  bit_next;
  reg         err_next;
  wire [23:0] rel_sum;

  // relative sum wraps within 24 bits, carry discarded
  // the displacement sign fills the upper sixteen bits
  assign rel_sum = next_pc + {{16{op_field[7]}}, op_field[7:0]};

  // combinational decode per operand kind
  always @*
  begin
    addr_next  = 24'h000000;
    data_next  = 32'h00000000;
    width_next = `WID_BYTE;
    sfr_next   = 1'b0;
    bit_next   = 3'd0;
    err_next   = 1'b0;
    case (op_kind)
      // bit 7 picks special function register space
      `OPK_SHORT_DIRECT:
      begin
        addr_next  = {16'h0000, op_field[7:0]};
        sfr_next   = op_field[`SFR_SPLIT_BIT];
        width_next = other_width;
      end
      // upper byte forced to zero: lowest 64K only
      `OPK_LONG_DIRECT:
        addr_next = {8'h00, op_field[15:0]};
      `OPK_BYTE_IMM:
        data_next = {24'h000000, op_field[7:0]};
      `OPK_WORD_IMM:
      begin
        data_next  = {`ZERO_WORD, op_field[15:0]};
        width_next = `WID_WORD;
      end
      `OPK_ZERO_EXT_IMM:
      begin
        data_next  = {`ZERO_WORD, op_field[15:0]};
        width_next = `WID_DWORD;
      end
      `OPK_ONE_EXT_IMM:
      begin
        data_next  = {`ONES_WORD, op_field[15:0]};
        width_next = `WID_DWORD;
      end
      `OPK_SHORT_IMM:
      begin
        // field 0,1,2 gives 1,2,4; code 3 is illegal
        if (op_field[1:0] == 2'd3)
          err_next = 1'b1;
        else
          data_next = 32'h00000001 << op_field[1:0];
      end
      `OPK_LEGACY_BIT:
      begin
        bit_next = op_field[2:0];
        // low half: sixteen RAM bytes of eight bits each
        if (!op_field[7])
          addr_next = {16'h0000, `BIT_RAM_BASE
                       + {4'h0, op_field[6:3]}};
        else
        begin
          // high half: register address a multiple of eight
          addr_next = {16'h0000, op_field[7:3], 3'b000};
          sfr_next  = 1'b1;
        end
      end
      `OPK_EXT_BIT:
      begin
        // field[22:3] byte address, field[2:0] bit; field[23] picks sfr
        bit_next  = op_field[2:0];
        sfr_next  = op_field[23];
        addr_next = {4'h0, op_field[22:3]};
        // low RAM bit outside its window is flagged, never wrapped
        if (!sfr_next && (addr_next < `EXT_BIT_LOW
                          || addr_next > `EXT_BIT_HIGH))
          err_next = 1'b1;
      end
      `OPK_REL:
        addr_next = rel_sum;
      // kept bits come straight from next_pc: no adder, no carry
      `OPK_BLOCK_JUMP:
        addr_next = {next_pc[23:`BLOCK_BITS],
                     op_field[`BLOCK_BITS-1:0]};
      `OPK_REGION_JUMP:
        addr_next = {next_pc[23:`REGION_BITS],
                     op_field[`REGION_BITS-1:0]};
      // whole address replaced; any region is reachable
      `OPK_FULL_JUMP:
        addr_next = op_field;
      default:
        err_next = 1'b1;                            // unknown kind
    endcase
  end

  // registered result, one clock after request
  // fields hold until the next request; valid pulses one clock
  // an illegal request still answers, with res_error set
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      res_valid  <= 1'b0;
      res_addr   <= 24'h000000;
      res_data   <= 32'h00000000;
      res_width  <= `WID_BYTE;
      res_is_sfr <= 1'b0;
      res_bit    <= 3'd0;
      res_error  <= 1'b0;
    end
    else
    begin
      res_valid <= op_valid;
      if (op_valid)
      begin
        res_addr   <= addr_next;
        res_data   <= data_next;
        res_width  <= width_next;
        res_is_sfr <= sfr_next;
        res_bit    <= bit_next;
        res_error  <= err_next;
      end
    end
  end

endmodule // operand_address_decode

// >>> operand_address_decode_defines.vh
// constants for the operand and address decode block
// assumes inclusion by bare name from the design file
`ifndef OPERAND_ADDRESS_DECODE_DEFINES_VH
`define OPERAND_ADDRESS_DECODE_DEFINES_VH

// ****************************************************
// state timing
// ****************************************************
`define CLKS_PER_STATE      2'd2
// ****************************************************
// operand kinds on op_kind
// ****************************************************
`define OPK_SHORT_DIRECT    4'h0
`define OPK_LONG_DIRECT     4'h1
`define OPK_BYTE_IMM        4'h2
`define OPK_WORD_IMM        4'h3
`define OPK_ZERO_EXT_IMM    4'h4
`define OPK_ONE_EXT_IMM     4'h5
`define OPK_SHORT_IMM       4'h6
`define OPK_LEGACY_BIT      4'h7
`define OPK_EXT_BIT         4'h8
`define OPK_REL             4'h9
`define OPK_BLOCK_JUMP      4'ha
`define OPK_REGION_JUMP     4'hb
`define OPK_FULL_JUMP       4'hc
// ****************************************************
// operand width codes
// ****************************************************
`define WID_BYTE            2'h0
`define WID_WORD            2'h1
`define WID_DWORD           2'h2
// ****************************************************
// address constants
// ****************************************************
`define SFR_SPLIT_BIT       7
`define BIT_RAM_BASE        8'h20
`define EXT_BIT_LOW         24'h000020
`define EXT_BIT_HIGH        24'h00007f
`define BLOCK_BITS          11
`define REGION_BITS         16
`define ONES_WORD           16'hffff
`define ZERO_WORD           16'h0000
// ****************************************************
// wait state decode
// ****************************************************
`define NONPAGE_BASE_STATES 3'd2
`define PAGE_STATES         3'd1

`endif

// >>> operand_address_decode_monitor.sv
// concurrent checks on the operand decode block
// assumes a bind onto the block, ports matched by name
`timescale 1ns/1ns
module operand_address_decode_monitor (
  input wire        clk,
  input wire        resetn,
  input wire        op_valid,
  input wire [3:0]  op_kind,
  input wire [23:0] op_field,
  input wire [23:0] next_pc,
  input wire        res_valid,
  input wire [23:0] res_addr,
  input wire [31:0] res_data,
  input wire        res_is_sfr,
  input wire        state_tick
);
  // ****************
  // tick and result checks
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_state_tick_gap: assert property (
    state_tick |=> !state_tick ##1 state_tick) else $error("tick gap");
  a_short_direct_split: assert property (
    op_valid && op_kind == 4'h0 |=> res_is_sfr == $past(op_field[7]))
    else $error("short direct split");
  a_long_direct_low: assert property (
    op_valid && op_kind == 4'h1 |=> res_addr[23:16] == 8'h00)
    else $error("long direct region");
  a_zero_fill_upper: assert property (
    op_valid && op_kind == 4'h4 |=> res_data[31:16] == 16'h0000)
    else $error("zero fill");
  a_one_fill_upper: assert property (
    op_valid && op_kind == 4'h5 |=> res_data[31:16] == 16'hffff)
    else $error("one fill");
  a_block_jump_keep: assert property (
    op_valid && op_kind == 4'ha |=> res_addr[23:11] == $past(next_pc[23:11])
    && res_addr[10:0] == $past(op_field[10:0])) else $error("block jump");
  a_region_jump_keep: assert property (
    op_valid && op_kind == 4'hb |=> res_addr[23:16] == $past(next_pc[23:16])
    && res_addr[15:0] == $past(op_field[15:0])) else $error("region jump");
  a_full_jump_load: assert property (
    op_valid && op_kind == 4'hc |=> res_valid && res_addr == $past(op_field))
    else $error("full jump");
endmodule // operand_address_decode_monitor

bind operand_address_decode operand_address_decode_monitor u_mon (.*);

// >>> ext_code_model.sv
// external program memory handing out bytes a0, a1, ...
// assumes a byte is taken on ext_fetch_req with state_tick
`timescale 1ns/1ns
module ext_code_model (
  input  wire       clk,
  input  wire       en,
  input  wire       ext_fetch_req,
  input  wire       state_tick,
  output reg  [7:0] ext_code_byte,
  output reg        ext_code_valid
);
  reg  [7:0] idx_reg;  // offset of byte on offer
  wire       take_w = ext_fetch_req && state_tick && ext_code_valid;
  initial
  begin
    {idx_reg, ext_code_byte, ext_code_valid} = 17'h0005a;
  end
  // next byte after each take, scrambled bus while idle
  always @(posedge clk)
  begin
    idx_reg <= en ? idx_reg + {7'h00, take_w} : 8'h00;
    ext_code_valid <= en;
    ext_code_byte <= en ? 8'ha0 + idx_reg + {7'h00, take_w} : ~ext_code_byte;
  end
endmodule // ext_code_model

// >>> operand_address_decode_tb.sv
// self-checking bench for the operand decode block
// assumes the external code model and the bound checker
`timescale 1ns/1ns
`include "operand_address_decode_defines.vh"
module operand_address_decode_tb;
  reg         clk, resetn, cfg_source_mode, cfg_nonpage, en;
  reg         wait_count_hi_n, wait_count_lo_n, code_external;
  reg         int_code_valid, exec_take, op_valid;
  reg  [15:0] int_code_word;
  reg  [3:0]  op_kind;
  reg  [1:0]  other_width;
  reg  [23:0] op_field, next_pc;
  wire [7:0]  ext_code_byte, exec_byte;
  wire        ext_code_valid, ext_fetch_req, exec_byte_valid, res_valid;
  wire        res_is_sfr, res_error, source_mode, page_mode, state_tick;
  wire [23:0] res_addr;
  wire [31:0] res_data;
  wire [1:0]  res_width;
  wire [2:0]  res_bit, wait_states;
  integer     num_errors, checks_done, cyc, acc, c1, i;
  // ****************
  // clock, design, model
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  operand_address_decode DUT (.*);
  ext_code_model mem (.*);
  // cycle count, taken external bytes, hang guard
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (code_external && ext_fetch_req && state_tick && ext_code_valid)
      acc = acc + 1;
    if (cyc == 2000)
    begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end
  task chk(input [95:0] n, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (e !== g)
      begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task pulse_take;
    begin
      @(posedge clk);
      exec_take <= 1'b1;
      @(posedge clk);
      exec_take <= 1'b0;
      @(posedge clk);
    end
  endtask
  task op(input [3:0] k, input [1:0] w, input [23:0] f, input [23:0] p);
    begin
      @(posedge clk);
      {op_valid, op_kind, other_width} <= {1'b1, k, w};
      {op_field, next_pc} <= {f, p};
      @(posedge clk);
      op_valid <= 1'b0;
      #1 chk("res_valid", 1'h1, res_valid);
      @(posedge clk);
      #1 chk("res_pulse", 1'h0, res_valid);
    end
  endtask
  // ****************
  // scenarios
  // ****************
  // every wait code and both settings of each mode bit, reset values first
  task t_config;
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge clk);
      resetn <= 1'b0;
      {cfg_source_mode, cfg_nonpage} <= i[1:0];
      {wait_count_hi_n, wait_count_lo_n} <= i[1:0];
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      #1 chk("page_mode", 1'h1, page_mode);
      chk("wait_states", 3'h3, wait_states);
      repeat (2) @(posedge clk);
      #1 chk("wait_states", 3 - i, wait_states);
      chk("page_mode", !i[0], page_mode);
      chk("source_mode", i[1], source_mode);
    end
  endtask
  // operand kinds, boundaries and kept address bits
  task t_ops;
    begin
      op(`OPK_SHORT_DIRECT, `WID_WORD, 24'h000045, 24'h0);
      chk("sfr", 1'h0, res_is_sfr);
      chk("width", `WID_WORD, res_width);
      op(`OPK_SHORT_DIRECT, `WID_DWORD, 24'h0000c8, 24'h0);
      chk("sfr", 1'h1, res_is_sfr);
      chk("width", `WID_DWORD, res_width);
      op(`OPK_LONG_DIRECT, 2'h0, 24'h12abcd, 24'h0);
      chk("addr", 24'h00abcd, res_addr);
      op(`OPK_BYTE_IMM, 2'h0, 24'h001234, 24'h0);
      chk("data", 32'h34, res_data);
      op(`OPK_WORD_IMM, 2'h1, 24'h001234, 24'h0);
      chk("data", 32'h1234, res_data);
      op(`OPK_ONE_EXT_IMM, 2'h2, 24'h008001, 24'h0);
      chk("data", 32'hffff8001, res_data);
      op(`OPK_ZERO_EXT_IMM, 2'h2, 24'hab8001, 24'h0);
      chk("data", 32'h00008001, res_data);
      chk("width", `WID_DWORD, res_width);
      for (i = 0; i < 4; i = i + 1)
      begin
        op(`OPK_SHORT_IMM, 2'h0, i, 24'h0);
        chk("error", i == 3, res_error);
        if (i < 3)
          chk("data", 32'h1 << i, res_data);
      end
      op(`OPK_LEGACY_BIT, 2'h0, 24'h00005b, 24'h0);
      chk("addr", {24'h2b, 3'h3}, {res_addr, res_bit});
      op(`OPK_LEGACY_BIT, 2'h0, 24'h0000d6, 24'h0);
      chk("addr", {24'hd0, 3'h6}, {res_addr, res_bit});
      op(`OPK_EXT_BIT, 2'h0, 24'h0003fd, 24'h0);
      chk("addr", {24'h7f, 3'h5}, {res_addr, res_bit});
      chk("error", 1'h0, res_error);
      op(`OPK_EXT_BIT, 2'h0, 24'h000400, 24'h0);
      chk("error", 1'h1, res_error);
      op(`OPK_REL, 2'h0, 24'h0000fe, 24'h000100);
      chk("addr", 24'h0000fe, res_addr);
      op(`OPK_REL, 2'h0, 24'h000020, 24'hfffff0);
      chk("addr", 24'h000010, res_addr);
      op(`OPK_BLOCK_JUMP, 2'h0, 24'h0005a5, 24'h1237fe);
      chk("addr", 24'h1235a5, res_addr);
      op(`OPK_REGION_JUMP, 2'h0, 24'h120010, 24'h34fffe);
      chk("addr", 24'h340010, res_addr);
      op(`OPK_FULL_JUMP, 2'h0, 24'habcdef, 24'h0);
      chk("addr", 24'habcdef, res_addr);
    end
  endtask
  // state ticks, then one internal word popped low byte first
  task t_fetch_int;
    begin
      acc = 0;
      repeat (20) @(negedge clk) acc = acc + state_tick;
      chk("ticks", 10, acc);
      @(posedge clk);
      {code_external, int_code_word, int_code_valid} <= 18'h0b2a1 << 1 | 1;
      @(posedge clk);
      int_code_valid <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("exec_byte", 8'ha1, exec_byte);
      pulse_take;
      @(posedge clk);
      #1 chk("exec_byte", 8'hb2, exec_byte);
      pulse_take;
      #1 chk("byte_valid", 1'h0, exec_byte_valid);
    end
  endtask
  // non-page, no waits: pacing, full queue, drain while refilling
  task t_fetch_ext;
    begin
      @(posedge clk);
      {code_external, en} <= 2'h3;
      acc = 0;
      while (acc < 1) @(negedge clk);
      c1 = cyc;
      while (acc < 2) @(negedge clk);
      chk("byte_gap", 4, cyc - c1);
      repeat (40) @(posedge clk);
      #1 chk("queued", 4, acc);
      chk("fetch_req", 1'h0, ext_fetch_req);
      for (i = 0; i < 6; i = i + 1)
      begin
        #1 chk("exec_byte", 8'ha0 + i, exec_byte);
        pulse_take;
      end
    end
  endtask
  // reset into a fetch mode, then time two external bytes
  task gap(input np, input [1:0] wc, input [31:0] want);
    begin
      @(posedge clk);
      resetn <= 1'b0;
      {cfg_nonpage, wait_count_hi_n, wait_count_lo_n} <= {np, wc};
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      acc = 0;
      while (acc < 1) @(negedge clk);
      c1 = cyc;
      while (acc < 2) @(negedge clk);
      chk("byte_gap", want, cyc - c1);
    end
  endtask
  // page mode one state per byte, non-page with three waits
  task t_fetch_page;
    begin
      gap(1'b0, 2'h2, 2);
      gap(1'b1, 2'h0, 10);
    end
  endtask
  initial
  begin
    {resetn, cfg_source_mode, cfg_nonpage, en, code_external} = 5'h0;
    {wait_count_hi_n, wait_count_lo_n, int_code_valid} = 3'h0;
    {exec_take, op_valid, int_code_word} = 18'h0;
    {op_kind, other_width, op_field, next_pc} = 54'h0;
    {num_errors, checks_done, cyc, acc} = 128'h0;
    t_config;
    $display("config done");
    t_ops;
    $display("operands done");
    t_fetch_int;
    $display("internal fetch done");
    t_fetch_ext;
    $display("external fetch done");
    t_fetch_page;
    $display("fetch pacing done");
    end_of_test;
  end
endmodule // operand_address_decode_tb
